// *** hdl/afs_status_control.sv ***
// status and control register group of the sampling acquisition card
// Behaviour
// - status bit 0 set while queue not full
// - status bit 1 set when queue half occupied
// - status bit 2 set while queue holds samples
// - status bit 3 set when post counter zero
// - status bit 4 set once trigger detected
// - status bit 5 set only while actually sampling
// - offset 18h reads status, writes control
// - control bit 0 one empties the queue
// - control bit 1 one clears trigger flag
// - offset 1ch bit 0 arms or disables
// - bits 2..1 choose source, 11 illegal
// - clock select write-only at 20h
// - external source uses the same divider
// - queue holds 32K samples
// - conversion starts only after trigger
// - samples leave by dma stream
// - 16-bit post counter, preload, decrement, halt
`timescale 1ns/1ns
module afs_status_control #(
  parameter int DATA_W = afs_pkg::SAMPLE_W,
  parameter int DEPTH = afs_pkg::QUEUE_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] post_count_preload,
  input wire logic post_count_load,
  input wire logic [15:0] sample_clock_divisor,
  input wire logic trigger_event,
  input wire logic osc_clk_in,
  input wire logic ext_sine_clk,
  input wire logic ext_dig_clk,
  input wire logic [DATA_W-1:0] adc_sample,
  output logic dma_valid,
  input wire logic dma_ready,
  output logic [DATA_W-1:0] dma_data,
  output logic conv_freq_above_bus
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  afs_pkg::afs_state_e state_r; // acquisition sequence
  afs_pkg::afs_state_e state_nxt;
  logic trigger_seen_flag_r;     // sticky detection flag
  logic [afs_pkg::POST_COUNT_W-1:0] post_cnt_r; // post trigger down counter
  logic [1:0] conv_clock_select_field_r; // chosen conversion source
  logic freq_sel_r;              // source faster than the host bus
  logic [31:0] rdata_r;          // registered read answer
  logic sample_tick;             // one rising sampling edge
  logic ctrl_wr;                 // write to shared status/control offset
  logic enable_wr;               // write to capture enable
  logic clksel_wr;               // write to clock select
  logic queue_flush_bit;         // flush requested by this write
  logic trigger_seen_clear_bit;  // trigger clear requested by this write
  logic capture_enable_bit;      // arm or disarm value written
  logic trig_set;                // trigger accepted this cycle
  logic post_count_zero_flag;    // counter has reached zero
  logic sampling_active_flag;    // samples being converted
  logic [afs_pkg::STAT_USED_W-1:0] status_bits; // live status view

  // queue carrier
  afs_queue_if #(.DATA_W(DATA_W)) qif ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // exact match on the full byte address; other addresses are ignored
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    addr_is = (addr == ofs);
  endfunction

  // 0x18 is shared: a read sees status, a write acts on the queue
  assign ctrl_wr = reg_wr && addr_is(reg_addr, afs_pkg::OFS_BUFFER_CONTROL);
  assign enable_wr = reg_wr && addr_is(reg_addr, afs_pkg::OFS_CAPTURE_ENABLE);
  assign clksel_wr = reg_wr && addr_is(reg_addr, afs_pkg::OFS_CONV_CLOCK_SELECT);

  // only ones act; zero bits leave everything alone
  assign queue_flush_bit = ctrl_wr && reg_wdata[afs_pkg::CTRL_FLUSH_POS];
  assign trigger_seen_clear_bit = ctrl_wr && reg_wdata[afs_pkg::CTRL_TRIG_CLEAR_POS];
  // upper bits of the enable word are ignored
  assign capture_enable_bit = reg_wdata[afs_pkg::CAPT_ENABLE_POS];

  // ----------------------------------------------------------------
  // clock source register
  // ----------------------------------------------------------------
  // write-only; bits 31..3 dropped
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      conv_clock_select_field_r <= afs_pkg::CLKSEL_RESET;
      freq_sel_r <= afs_pkg::FREQ_SEL_RESET;
    end
    else if (clksel_wr)
    begin
      conv_clock_select_field_r <= reg_wdata[afs_pkg::CLKSEL_HI_POS:afs_pkg::CLKSEL_LO_POS];
      freq_sel_r <= reg_wdata[afs_pkg::CLKSEL_FREQ_POS];
    end
  end

  // range hint handed to the bus interface timing logic
  assign conv_freq_above_bus = freq_sel_r;

  // ----------------------------------------------------------------
  // sampling clock
  // ----------------------------------------------------------------
  afs_sample_clock u_clk (
    .core_clk(core_clk),
    .rst(rst),
    .osc_clk_in(osc_clk_in),
    .ext_sine_clk(ext_sine_clk),
    .ext_dig_clk(ext_dig_clk),
    .conv_clock_select_field(conv_clock_select_field_r),
    .sample_clock_divisor(sample_clock_divisor),
    .sample_tick(sample_tick)
  );

  // ----------------------------------------------------------------
  // acquisition sequence
  // ----------------------------------------------------------------
  // a trigger only counts while armed and waiting
  assign trig_set = (state_r == afs_pkg::AFS_WAIT_TRIG) && trigger_event;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      afs_pkg::AFS_IDLE:
      begin
        // writing one arms the card
        if (enable_wr && capture_enable_bit)
          state_nxt = afs_pkg::AFS_WAIT_TRIG;
      end
      afs_pkg::AFS_WAIT_TRIG:
      begin
        // conversions start only on the trigger
        if (enable_wr && !capture_enable_bit)
          state_nxt = afs_pkg::AFS_IDLE;
        else if (trigger_event)
          state_nxt = afs_pkg::AFS_ACQUIRE;
      end
      afs_pkg::AFS_ACQUIRE:
      begin
        // re-arming while sampling keeps sampling; zero stops it
        if (enable_wr && !capture_enable_bit)
          state_nxt = afs_pkg::AFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_r <= afs_pkg::AFS_IDLE;
    else
      state_r <= state_nxt;
  end

  assign sampling_active_flag = (state_r == afs_pkg::AFS_ACQUIRE);

  // ----------------------------------------------------------------
  // trigger detection flag
  // ----------------------------------------------------------------
  // set beats clear so a trigger in the clearing cycle is kept
  // disabling leaves the flag alone; only the clear bit drops it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      trigger_seen_flag_r <= 1'b0;
    else if (trig_set)
      trigger_seen_flag_r <= 1'b1;
    else if (trigger_seen_clear_bit)
      trigger_seen_flag_r <= 1'b0;
    // otherwise the flag holds, it never decays by itself
  end

  // ----------------------------------------------------------------
  // post trigger counter
  // ----------------------------------------------------------------
  // preload wins; counting needs a seen trigger and a sampling edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
      post_cnt_r <= afs_pkg::POST_COUNT_RESET;
    else if (post_count_load)
      post_cnt_r <= post_count_preload;
    else if (trigger_seen_flag_r && sample_tick && (post_cnt_r != '0))
      post_cnt_r <= post_cnt_r - 1'b1;
  end

  // the counter parks at zero until the next preload
  assign post_count_zero_flag = (post_cnt_r == '0);

  // ----------------------------------------------------------------
  // sample queue
  // ----------------------------------------------------------------
  // push on each sampling edge while acquiring; a full queue drops it
  // the dma side shares core_clk, so nothing crosses a domain here
  assign qif.push = sampling_active_flag && sample_tick;
  assign qif.push_data = adc_sample;
  assign qif.flush = queue_flush_bit;

  afs_sample_queue #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_queue (
    .core_clk(core_clk),
    .rst(rst),
    .q(qif.queue),
    .dma_valid(dma_valid),
    .dma_ready(dma_ready),
    .dma_data(dma_data)
  );

  // ----------------------------------------------------------------
  // status view and read port
  // ----------------------------------------------------------------
  // a live view; reading it never touches a flag or the queue
  assign status_bits[afs_pkg::STAT_NOT_FULL_POS] = !qif.full;
  assign status_bits[afs_pkg::STAT_HALF_POS] = qif.half;
  assign status_bits[afs_pkg::STAT_NOT_EMPTY_POS] = !qif.empty;
  assign status_bits[afs_pkg::STAT_POST_ZERO_POS] = post_count_zero_flag;
  assign status_bits[afs_pkg::STAT_TRIG_SEEN_POS] = trigger_seen_flag_r;
  assign status_bits[afs_pkg::STAT_ACTIVE_POS] = sampling_active_flag;

  // answer one cycle after the strobe; write-only offsets read zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd)
    begin
      if (addr_is(reg_addr, afs_pkg::OFS_BUFFER_STATUS))
        rdata_r <= {26'h000_0000, status_bits};
      else
        rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // these watch only what this module drives
  a_flush_empties: assert property (@(posedge core_clk) disable iff (rst)
    queue_flush_bit |=> qif.empty)
    else $error("queue not empty after flush write");

  a_trig_clear: assert property (@(posedge core_clk) disable iff (rst)
    trigger_seen_clear_bit && !trig_set |=> !trigger_seen_flag_r)
    else $error("trigger flag survived clear");

  a_trig_sticky: assert property (@(posedge core_clk) disable iff (rst)
    trigger_seen_flag_r && !trigger_seen_clear_bit |=> trigger_seen_flag_r)
    else $error("trigger flag dropped by itself");

  a_set_beats_clear: assert property (@(posedge core_clk) disable iff (rst)
    trig_set && trigger_seen_clear_bit
    |=> trigger_seen_flag_r && status_bits[afs_pkg::STAT_TRIG_SEEN_POS])
    else $error("trigger lost in clearing cycle");

  a_arm_waits: assert property (@(posedge core_clk) disable iff (rst)
    state_r == afs_pkg::AFS_IDLE && enable_wr && capture_enable_bit
    |=> state_r == afs_pkg::AFS_WAIT_TRIG && !sampling_active_flag)
    else $error("arm write did not arm");

  a_disable_stops: assert property (@(posedge core_clk) disable iff (rst)
    enable_wr && !capture_enable_bit |=> !sampling_active_flag [*2])
    else $error("still active after disable");

  a_push_needs_trig: assert property (@(posedge core_clk) disable iff (rst)
    qif.push |-> $past(state_r) != afs_pkg::AFS_IDLE && sampling_active_flag)
    else $error("sample pushed before trigger");

  a_count_halt: assert property (@(posedge core_clk) disable iff (rst)
    post_count_zero_flag && !post_count_load |=> post_cnt_r == '0)
    else $error("post counter left zero");

  a_count_step: assert property (@(posedge core_clk) disable iff (rst)
    trigger_seen_flag_r && sample_tick && !post_count_zero_flag && !post_count_load
    |=> post_cnt_r == $past(post_cnt_r) - 16'h0001)
    else $error("post counter missed a step");

  a_status_read: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && addr_is(reg_addr, afs_pkg::OFS_BUFFER_STATUS)
    |=> reg_rdata == {26'h000_0000, $past(status_bits)})
    else $error("status read mismatch");

  a_read_quiet: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && !reg_wr && !trig_set |=> trigger_seen_flag_r == $past(trigger_seen_flag_r))
    else $error("read disturbed a flag");

  a_zero_keeps: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_wr && !queue_flush_bit && !qif.empty && !dma_ready |=> !qif.empty)
    else $error("zero write lost samples");

  a_trig_starts: assert property (@(posedge core_clk) disable iff (rst)
    trig_set && !enable_wr |=> sampling_active_flag && trigger_seen_flag_r)
    else $error("trigger did not start sampling");

  a_trig_waits: assert property (@(posedge core_clk) disable iff (rst)
    state_r == afs_pkg::AFS_WAIT_TRIG && !trigger_event |=> !sampling_active_flag)
    else $error("sampling before trigger");

  a_rearm_keeps: assert property (@(posedge core_clk) disable iff (rst)
    enable_wr && capture_enable_bit && state_r != afs_pkg::AFS_IDLE && !trigger_event
    |=> state_r == $past(state_r))
    else $error("re-arm changed the sequence");

  a_post_hold: assert property (@(posedge core_clk) disable iff (rst)
    !trigger_seen_flag_r && !post_count_load |=> $stable(post_cnt_r))
    else $error("post counter moved early");

  a_post_preload: assert property (@(posedge core_clk) disable iff (rst)
    post_count_load |=> post_cnt_r == $past(post_count_preload))
    else $error("preload lost");

  a_clksel_hold: assert property (@(posedge core_clk) disable iff (rst)
    !clksel_wr |=> $stable(conv_clock_select_field_r) && $stable(freq_sel_r))
    else $error("clock select changed unwritten");

  a_clksel_take: assert property (@(posedge core_clk) disable iff (rst)
    clksel_wr |=> conv_clock_select_field_r ==
      $past(reg_wdata[afs_pkg::CLKSEL_HI_POS:afs_pkg::CLKSEL_LO_POS]))
    else $error("clock source not taken");

  a_freq_take: assert property (@(posedge core_clk) disable iff (rst)
    clksel_wr |=> conv_freq_above_bus == $past(reg_wdata[afs_pkg::CLKSEL_FREQ_POS]))
    else $error("range hint not taken");

  a_rdata_stands: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read answer changed");

  a_other_reads: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && !addr_is(reg_addr, afs_pkg::OFS_BUFFER_STATUS) |=> reg_rdata == 32'h0000_0000)
    else $error("other offset read not zero");

endmodule

// *** pkg/afs_pkg.sv ***
// shared constants for the acquisition status and control register group
package afs_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BUFFER_STATUS = 8'h18;  // read side of the shared offset
  localparam logic [7:0] OFS_BUFFER_CONTROL = 8'h18; // write side of the shared offset
  localparam logic [7:0] OFS_CAPTURE_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_CONV_CLOCK_SELECT = 8'h20;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int STAT_NOT_FULL_POS = 0;
  localparam int STAT_HALF_POS = 1;
  localparam int STAT_NOT_EMPTY_POS = 2;
  localparam int STAT_POST_ZERO_POS = 3;
  localparam int STAT_TRIG_SEEN_POS = 4;
  localparam int STAT_ACTIVE_POS = 5;
  localparam int STAT_USED_W = 6;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_FLUSH_POS = 0;
  localparam int CTRL_TRIG_CLEAR_POS = 1;
  localparam int CAPT_ENABLE_POS = 0;
  localparam int CLKSEL_FREQ_POS = 0;
  localparam int CLKSEL_LO_POS = 1;
  localparam int CLKSEL_HI_POS = 2;

  // ----------------------------------------------------------------
  // conversion clock source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CLKSRC_INTERNAL = 2'h0;
  localparam logic [1:0] CLKSRC_EXT_SINE = 2'h1;
  localparam logic [1:0] CLKSRC_EXT_DIGITAL = 2'h2;
  localparam logic [1:0] CLKSRC_ILLEGAL = 2'h3;

  // ----------------------------------------------------------------
  // values after reset and sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] CLKSEL_RESET = 2'h0;
  localparam logic FREQ_SEL_RESET = 1'b0;
  localparam logic [15:0] POST_COUNT_RESET = 16'h0000;
  localparam logic [15:0] DIVISOR_MIN = 16'h0002;
  localparam int QUEUE_DEPTH = 32768;
  localparam int SAMPLE_W = 16;
  localparam int POST_COUNT_W = 16;
  localparam int SYNC_STAGES = 2;

  // acquisition sequencing
  typedef enum logic [1:0] {AFS_IDLE, AFS_WAIT_TRIG, AFS_ACQUIRE} afs_state_e;

endpackage

// *** pkg/afs_queue_if.sv ***
// carrier between the register group and the sample queue
`timescale 1ns/1ns
interface afs_queue_if #(
  parameter int DATA_W = 16
);
  logic push;                // one sample offered this cycle
  logic [DATA_W-1:0] push_data; // the sample itself
  logic flush;               // drop everything held
  logic full;                // no room left
  logic half;                // at least half occupied
  logic empty;               // nothing held

  modport ctrl (output push, output push_data, output flush, input full, input half, input empty);
  modport queue (input push, input push_data, input flush, output full, output half, output empty);
endinterface

// *** hdl/afs_sample_queue.sv ***
// sample queue held in flip-flops, drained by the dma stream
`timescale 1ns/1ns
module afs_sample_queue #(
  parameter int DATA_W = 16,
  parameter int DEPTH = 32768
) (
  input wire logic core_clk,
  input wire logic rst,
  afs_queue_if.queue q,
  output logic dma_valid,
  input wire logic dma_ready,
  output logic [DATA_W-1:0] dma_data
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  logic [DATA_W-1:0] mem_r [DEPTH]; // sample storage
  logic [AW-1:0] wr_ptr_r;          // next slot to fill
  logic [AW-1:0] rd_ptr_r;          // oldest sample
  logic [AW:0] count_r;             // samples held
  logic do_push;
  logic do_pop;

  // a full queue silently refuses the sample; the source sees full
  assign do_push = q.push && !q.full;
  assign do_pop = dma_valid && dma_ready;

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (do_push)
    begin
      mem_r[wr_ptr_r] <= q.push_data;
    end
  end

  // flush wins over a push or pop in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (rst || q.flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (do_push && !do_pop)
        count_r <= count_r + 1'b1;
      else if (do_pop && !do_push)
        count_r <= count_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // fill flags and dma side
  // ----------------------------------------------------------------
  assign q.full = (count_r == (AW+1)'(DEPTH));
  assign q.half = (count_r >= (AW+1)'(DEPTH / 2));
  assign q.empty = (count_r == '0);
  assign dma_valid = !q.empty;
  assign dma_data = mem_r[rd_ptr_r];

  a_flush_clears: assert property (@(posedge core_clk) disable iff (rst)
    q.flush |=> (count_r == '0) && (wr_ptr_r == rd_ptr_r))
    else $error("queue not empty after flush");
  a_count_bound: assert property (@(posedge core_clk) disable iff (rst)
    count_r <= (AW+1)'(DEPTH))
    else $error("queue overfilled");
endmodule

// *** hdl/afs_sample_clock.sv ***
// conversion source selection and even divider giving the sampling tick
`timescale 1ns/1ns
module afs_sample_clock (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic osc_clk_in,
  input wire logic ext_sine_clk,
  input wire logic ext_dig_clk,
  input wire logic [1:0] conv_clock_select_field,
  input wire logic [15:0] sample_clock_divisor,
  output logic sample_tick
);
  logic [2:0] pins;
  logic [2:0] sync1_r; // first stage, read only by the second
  logic [2:0] sync2_r;
  logic [2:0] prev_r;  // for edge detection
  logic src_edge;
  logic [15:0] div_eff;
  logic [15:0] div_cnt_r;

  assign pins = {ext_dig_clk, ext_sine_clk, osc_clk_in};

  // ----------------------------------------------------------------
  // pin synchronisers; sources above half the core rate alias
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        sync1_r[gi] <= pins[gi];
        sync2_r[gi] <= sync1_r[gi];
        prev_r[gi] <= sync2_r[gi];
      end
    end
  endgenerate

  // illegal code selects nothing so no sample is ever taken
  always_comb
  begin
    unique case (conv_clock_select_field)
      afs_pkg::CLKSRC_INTERNAL: src_edge = sync2_r[0] && !prev_r[0];
      afs_pkg::CLKSRC_EXT_SINE: src_edge = sync2_r[1] && !prev_r[1];
      afs_pkg::CLKSRC_EXT_DIGITAL: src_edge = sync2_r[2] && !prev_r[2];
      afs_pkg::CLKSRC_ILLEGAL: src_edge = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // divider: low bit forced to zero, floor of two
  // ----------------------------------------------------------------
  assign div_eff = ({sample_clock_divisor[15:1], 1'b0} < afs_pkg::DIVISOR_MIN) ?
                   afs_pkg::DIVISOR_MIN : {sample_clock_divisor[15:1], 1'b0};

  // same divider for internal and external sources
  always_ff @(posedge core_clk)
  begin
    if (rst)
      div_cnt_r <= '0;
    else if (src_edge)
      div_cnt_r <= (div_cnt_r >= div_eff - 16'h0001) ? 16'h0000 : div_cnt_r + 16'h0001;
  end

  assign sample_tick = src_edge && (div_cnt_r >= div_eff - 16'h0001);

  a_illegal_quiet: assert property (@(posedge core_clk) disable iff (rst)
    conv_clock_select_field == afs_pkg::CLKSRC_ILLEGAL |-> !sample_tick)
    else $error("tick from illegal clock source");
  a_tick_spacing: assert property (@(posedge core_clk) disable iff (rst)
    sample_tick |=> !sample_tick)
    else $error("ticks back to back");
endmodule

// *** bench/afs_dma_sink.sv ***
// host-side dma sink model that pops queued samples, optionally stalling
`timescale 1ns/1ns
module afs_dma_sink (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic dma_valid,
  input wire logic [15:0] dma_data,
  input wire logic stall,
  output logic dma_ready,
  output logic [15:0] pop_count,
  output logic [15:0] last_data
);
  // ----------------------------------------------------------------
  // slow host: ready on every other cycle, none while stalled
  // ----------------------------------------------------------------
  logic phase_r; // alternating ready phase, tests back-pressure too
  always @(posedge core_clk)
  begin
    // a pop is taken at the edge where valid and ready are both high
    if (!rst && dma_valid && dma_ready)
    begin
      pop_count <= pop_count + 16'h0001;
      last_data <= dma_data;
    end
    if (rst)
    begin
      pop_count <= 16'h0000;
    end
    phase_r <= rst ? 1'b0 : !phase_r;
    dma_ready <= #1 !rst && !stall && phase_r;
  end
endmodule

// *** bench/acq_fifo_status_control_tb_top.sv ***
// self-checking bench for the acquisition status and control registers
`timescale 1ns/1ns
module acq_fifo_status_control_tb_top;
  // ----------------------------------------------------------------
  // stimulus signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [15:0] post_count_preload = 16'h0000;
  logic post_count_load = 1'b0;
  logic trigger_event = 1'b0;
  logic osc_clk_in = 1'b0;
  logic ext_sine_clk = 1'b0;
  logic ext_dig_clk = 1'b0;
  logic [15:0] adc_sample = 16'h5a3c; // constant word, easy to recognise
  logic dma_valid, dma_ready, conv_freq_above_bus;
  logic [15:0] dma_data, pop_count, last_data;
  logic stall = 1'b1; // host holds off the queue at first
  logic [15:0] divisor = 16'h0002;
  logic [31:0] v;
  int fails = 0;
  int n_compared = 0;
  // ----------------------------------------------------------------
  // clocks: core at 8 ns, sources unrelated in phase
  // ----------------------------------------------------------------
  always #4 core_clk = !core_clk;
  always #13 osc_clk_in = !osc_clk_in; // internal source near 40 mhz
  always #15 ext_sine_clk = !ext_sine_clk;
  always #11 ext_dig_clk = !ext_dig_clk;
  // small depth keeps fill and drain short
  afs_status_control #(.DATA_W(16), .DEPTH(16)) i_dut (.core_clk(core_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .post_count_preload(post_count_preload),
    .post_count_load(post_count_load), .sample_clock_divisor(divisor),
    .trigger_event(trigger_event), .osc_clk_in(osc_clk_in), .ext_sine_clk(ext_sine_clk),
    .ext_dig_clk(ext_dig_clk), .adc_sample(adc_sample), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_data(dma_data), .conv_freq_above_bus(conv_freq_above_bus));
  afs_dma_sink i_sink (.core_clk(core_clk), .rst(rst), .dma_valid(dma_valid),
    .dma_data(dma_data), .stall(stall), .dma_ready(dma_ready), .pop_count(pop_count),
    .last_data(last_data));
  // ----------------------------------------------------------------
  // access tasks: one-cycle strobes launched just after the edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata; // answer lands at the taking edge
  endtask
  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #1 s = 1'b1;
    @(posedge core_clk);
    #1 s = 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stat_is(input logic [31:0] m, input logic [31:0] exp);
    rd(8'h18, v);
    chk(v & m, exp);
  endtask
  // polls one status bit; running out of tries ends the run
  task automatic wait_bit(input int p, input logic val);
    for (int i = 0; i < 400; i++)
    begin
      rd(8'h18, v);
      if (v[p] === val) return;
    end
    fails++;
    report_and_stop();
  endtask
  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    stat_is(32'hffffffff, 32'h00000009);
    rd(8'h1c, v);
    chk(v, 32'h0);
    rd(8'h20, v);
    chk(v, 32'h0);
    rd(8'h44, v);
    chk(v, 32'h0);
    wr(8'h20, 32'hfffffff9);
    chk({31'h0, conv_freq_above_bus}, 32'h1);
    post_count_preload = 16'h0003;
    pulse(post_count_load);
    stat_is(32'h08, 32'h0);
    wr(8'h1c, 32'hfffffffe);
    wr(8'h1c, 32'h1);
    repeat (20) @(posedge core_clk);
    stat_is(32'h34, 32'h0);
    pulse(trigger_event);
    stat_is(32'h30, 32'h30);
    wait_bit(3, 1'b1);
    wait_bit(0, 1'b0);
    stat_is(32'h07, 32'h06);
    wr(8'h1c, 32'h0);
    stat_is(32'h30, 32'h10);
    wr(8'h18, 32'h0);
    stat_is(32'h17, 32'h16);
    wr(8'h18, 32'h2);
    stat_is(32'h17, 32'h06);
    stall = 1'b0;
    wait_bit(2, 1'b0);
    chk({16'h0, pop_count}, 32'd16);
    chk({16'h0, last_data}, 32'h5a3c);
    // every source code; the illegal one must give no samples
    for (int c = 0; c < 4; c++)
    begin
      stall = 1'b1;
      divisor = (c == 2) ? 16'h0001 : 16'h0002;
      wr(8'h20, {29'h0, c[1:0], 1'b0});
      chk({31'h0, conv_freq_above_bus}, 32'h0);
      wr(8'h18, 32'h3);
      wr(8'h1c, 32'h1);
      pulse(trigger_event);
      repeat (60) @(posedge core_clk);
      stat_is(32'h04, (c == 3) ? 32'h0 : 32'h4);
      wr(8'h1c, 32'h0);
      wr(8'h18, 32'h1);
      stat_is(32'h05, 32'h01);
      chk({31'h0, dma_valid}, 32'h0);
    end
    report_and_stop();
  end
endmodule
